// ---- logic/irq_prio_pkg.sv ----
package irq_prio_pkg;
  // register map on the plain register port
  localparam logic [7:0] ADDR_ENABLE     = 8'hA8; // interrupt_enable
  localparam logic [7:0] ADDR_PRIO_LOW   = 8'hB8; // interrupt_priority_low
  localparam logic [7:0] ADDR_PRIO_HIGH  = 8'hB7; // priority_high_register
  localparam logic [7:0] ADDR_POWER_CTL  = 8'h87; // idle and general flags
  localparam logic [7:0] ADDR_EV_STATUS  = 8'hC0; // sticky event status
  localparam logic [7:0] ADDR_EV_CLEAR   = 8'hC1; // write-one-to-clear
  localparam logic [7:0] ADDR_EV_ENABLE  = 8'hC2; // event irq enable
  localparam logic [7:0] ADDR_IN_SERVICE = 8'hC3; // levels in service
  localparam logic [7:0] RESET_BYTE      = 8'h00; // reset value of all regs

  // field positions
  localparam int GLOBAL_EN_BIT   = 7; // global_irq_enable
  localparam int IDLE_BIT        = 0; // idle_request_bit
  localparam int FLAG_ZERO_BIT   = 2; // general_flag_zero
  localparam int FLAG_ONE_BIT    = 3; // general_flag_one
  localparam int NUM_SOURCES     = 7; // sources, bit 0 polled first
  localparam int NUM_LEVELS      = 4; // priority levels 0..3
  localparam int NUM_CA_MODULES  = 5; // counter-array compare modules

  // event status bit positions
  localparam int EV_WAKE_BIT     = 0; // idle ended by an interrupt
  localparam int EV_ACCEPT_BIT   = 1; // an interrupt was accepted
  localparam int EV_PREEMPT_BIT  = 2; // a nested interrupt was accepted
  localparam int NUM_EVENTS      = 3;

  localparam logic [1:0] LEVEL_TOP = 2'h3; // highest priority level

  typedef enum logic [1:0] {
    CORE_RUN,  // cpu clocked
    CORE_IDLE  // cpu clock gated off
  } core_mode_type;

  // request handed to the cpu core
  typedef struct packed {
    logic       valid;  // a request wins
    logic [2:0] source; // winning source index (vector)
    logic [1:0] level;  // its level
  } irq_grant_type;
endpackage : irq_prio_pkg

// ---- logic/irq_level_resolve.sv ----
`timescale 1ns/10ps
// combinational arbiter: highest level, then fixed polling order
module irq_level_resolve
  import irq_prio_pkg::*;
(
  input  wire logic [NUM_SOURCES-1:0] pending_in,   // enabled requests
  input  wire logic [NUM_SOURCES-1:0] prio_low_in,  // low priority bits
  input  wire logic [NUM_SOURCES-1:0] prio_high_in, // high priority bits
  output irq_grant_type               grant_out     // winning request
);
  // level from the two priority bits
  function automatic logic [1:0] level_of(input logic hi, input logic lo);
    level_of = {hi, lo};
  endfunction : level_of

  always_comb begin
    grant_out = '0;
    // scan from last polled to first so the earliest index wins ties
    for (int i = NUM_SOURCES - 1; i >= 0; i--) begin
      if (pending_in[i] &&
          (!grant_out.valid ||
           level_of(prio_high_in[i], prio_low_in[i]) >=
           grant_out.level)) begin
        grant_out.valid  = 1'b1;
        grant_out.source = 3'(i);
        grant_out.level  = level_of(prio_high_in[i], prio_low_in[i]);
      end
    end
  end
endmodule : irq_level_resolve

// ---- logic/irq_prio_ctrl.sv ----
// Our own choice: the plain strobed port.
`timescale 1ns/10ps
module irq_prio_ctrl
  import irq_prio_pkg::*;
(
  input  wire logic                      core_clk_in,     // machine clock
  input  wire logic                      rst_in,          // sync reset
  input  wire logic [7:0]                reg_addr_in,     // register address
  input  wire logic [7:0]                reg_wdata_in,    // write data
  input  wire logic                      reg_wr_in,       // write strobe
  input  wire logic                      reg_rd_in,       // read strobe
  output logic      [7:0]                reg_rdata_out,   // read data
  input  wire logic                      ext0_req_in,     // ext int 0
  input  wire logic                      timer0_req_in,   // timer 0 ovf
  input  wire logic                      ext1_req_in,     // ext int 1
  input  wire logic                      timer1_req_in,   // timer 1 ovf
  input  wire logic                      serial_req_in,   // serial port
  input  wire logic                      timer2_req_in,   // timer 2 ovf
  input  wire logic [NUM_CA_MODULES-1:0] ca_module_req_in, // array modules
  input  wire logic                      ca_ovf_req_in,   // array overflow
  input  wire logic                      ack_in,          // core takes vector
  input  wire logic                      reti_in,         // return from isr
  output logic                           irq_valid_out,   // request to core
  output logic      [2:0]                irq_source_out,  // vector index
  output logic                           cpu_clk_en_out,  // cpu clock enable
  output logic                           periph_clk_en_out, // periph enable
  output logic                           hold_strobes_out, // strobes high
  output logic                           irq_out          // event interrupt
);
  localparam int LVL_W = NUM_LEVELS; // one in-service bit per level

  // complete block state
  typedef struct packed {
    logic [7:0]             enable;     // interrupt_enable
    logic [7:0]             prio_low;   // interrupt_priority_low
    logic [7:0]             prio_high;  // priority_high_register
    logic [7:0]             power_ctl;  // idle bit and general flags
    logic [NUM_EVENTS-1:0]  ev_status;  // sticky events
    logic [NUM_EVENTS-1:0]  ev_enable;  // event mask
    logic [LVL_W-1:0]       in_service; // levels being serviced
    core_mode_type          mode;       // run or idle
    logic [7:0]             rdata;      // registered read data
    logic                   irq_valid;  // registered request
    logic [2:0]             irq_source; // registered vector
    logic                   irq;        // registered event interrupt
  } state_type;

  state_type state_reg;  // registered state
  state_type state_next; // next state

  logic [NUM_SOURCES-1:0] raw_req;  // raw requests per source
  logic [NUM_SOURCES-1:0] pending;  // after enables
  irq_grant_type          grant;    // arbiter winner
  logic                   can_take; // winner may preempt
  logic [1:0]             cur_lvl;  // highest level in service
  logic                   busy;     // any level in service
  logic [NUM_EVENTS-1:0]  ev_set;   // event pulses this cycle
  logic [1:0]             offer_lvl; // level of the vector on offer

  // source order matches enable bit order, bit 0 polled first
  assign raw_req = {
    (|ca_module_req_in) | ca_ovf_req_in,
    timer2_req_in,
    serial_req_in,
    timer1_req_in,
    ext1_req_in,
    timer0_req_in,
    ext0_req_in
  };

  // global gate then per-source enables
  assign pending = state_reg.enable[GLOBAL_EN_BIT] ?
                   (raw_req & state_reg.enable[NUM_SOURCES-1:0]) :
                   '0;

  irq_level_resolve u_resolve (
    .pending_in   (pending),
    .prio_low_in  (state_reg.prio_low[NUM_SOURCES-1:0]),
    .prio_high_in (state_reg.prio_high[NUM_SOURCES-1:0]),
    .grant_out    (grant)
  );

  // highest in-service level as a number
  always_comb begin
    cur_lvl = 2'h0;
    for (int l = 0; l < NUM_LEVELS; l++) begin
      if (state_reg.in_service[l]) begin
        cur_lvl = 2'(l);
      end
    end
  end
  assign busy = |state_reg.in_service;

  // an ack marks in service the level of the vector on offer, even if a newer winner has
  // appeared since; the arbiter's current level could mark the wrong one
  assign offer_lvl = {state_reg.prio_high[state_reg.irq_source],
                      state_reg.prio_low[state_reg.irq_source]};

  // strictly higher level only; level 3 can never be beaten
  assign can_take = grant.valid &&
                    (!busy || grant.level > cur_lvl);

  // next-state logic
  always_comb begin
    state_next = state_reg;
    ev_set     = '0;
    state_next.rdata = RESET_BYTE;

    // register writes
    if (reg_wr_in) begin
      case (reg_addr_in)
        ADDR_ENABLE:    state_next.enable    = reg_wdata_in;
        // bit 7 kept as written; software must leave it clear
        ADDR_PRIO_LOW:  state_next.prio_low  = reg_wdata_in;
        ADDR_PRIO_HIGH: state_next.prio_high = reg_wdata_in;
        ADDR_POWER_CTL: state_next.power_ctl = reg_wdata_in;
        ADDR_EV_CLEAR:  state_next.ev_status =
                          state_reg.ev_status &
                          ~reg_wdata_in[NUM_EVENTS-1:0];
        ADDR_EV_ENABLE: state_next.ev_enable =
                          reg_wdata_in[NUM_EVENTS-1:0];
        default: ; // unmapped writes ignored
      endcase
    end

    // register reads, data appear next cycle
    if (reg_rd_in) begin
      case (reg_addr_in)
        ADDR_ENABLE:     state_next.rdata = state_reg.enable;
        ADDR_PRIO_LOW:   state_next.rdata = state_reg.prio_low;
        ADDR_PRIO_HIGH:  state_next.rdata = state_reg.prio_high;
        ADDR_POWER_CTL:  state_next.rdata = state_reg.power_ctl;
        ADDR_EV_STATUS:  state_next.rdata = 8'(state_reg.ev_status);
        ADDR_EV_ENABLE:  state_next.rdata = 8'(state_reg.ev_enable);
        ADDR_IN_SERVICE: state_next.rdata = 8'(state_reg.in_service);
        default:         state_next.rdata = RESET_BYTE;
      endcase
    end

    // service tracking: reti drops the top level first
    if (reti_in && busy) begin
      state_next.in_service[cur_lvl] = 1'b0;
    end
    if (ack_in && state_reg.irq_valid) begin
      state_next.in_service[offer_lvl] = 1'b1;
      ev_set[EV_ACCEPT_BIT] = 1'b1;
      ev_set[EV_PREEMPT_BIT] = busy;
    end

    // offer the winner to the core only when it may preempt
    state_next.irq_valid  = can_take;
    state_next.irq_source = grant.source;

    // idle entry and wake
    case (state_reg.mode)
      CORE_RUN: begin
        if (state_next.power_ctl[IDLE_BIT]) begin
          state_next.mode = CORE_IDLE;
        end
      end
      CORE_IDLE: begin
        if (grant.valid) begin
          // any enabled request wakes, then gets served
          state_next.power_ctl[IDLE_BIT] = 1'b0;
          state_next.mode = CORE_RUN;
          ev_set[EV_WAKE_BIT] = 1'b1;
        end
      end
      default: state_next.mode = CORE_RUN;
    endcase

    // set wins over a clear in the same cycle
    state_next.ev_status = state_next.ev_status | ev_set;
    state_next.irq = |(state_next.ev_status & state_next.ev_enable);
  end

  // state register; reset also ends idle
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      state_reg <= '{
        enable:     RESET_BYTE,
        prio_low:   RESET_BYTE,
        prio_high:  RESET_BYTE,
        power_ctl:  RESET_BYTE,
        ev_status:  '0,
        ev_enable:  '0,
        in_service: '0,
        mode:       CORE_RUN,
        rdata:      RESET_BYTE,
        irq_valid:  1'b0,
        irq_source: 3'h0,
        irq:        1'b0
      };
    end else begin
      state_reg <= state_next;
    end
  end

  // outputs from flops, peripheral enable tied high; cpu holds its state while gated
  assign reg_rdata_out     = state_reg.rdata;
  assign irq_valid_out     = state_reg.irq_valid;
  assign irq_source_out    = state_reg.irq_source;
  assign cpu_clk_en_out    = (state_reg.mode == CORE_RUN);
  assign periph_clk_en_out = 1'b1 | state_reg.irq;
  assign hold_strobes_out  = (state_reg.mode == CORE_IDLE);
  assign irq_out           = state_reg.irq;

  // assertions
  property p_idle_gates;
    @(posedge core_clk_in) disable iff (rst_in)
      (reg_wr_in && reg_addr_in == ADDR_POWER_CTL &&
       reg_wdata_in[IDLE_BIT] && cpu_clk_en_out)
      |=> !cpu_clk_en_out;
  endproperty
  a_idle_gates: assert property (p_idle_gates)
    else $error("idle request did not gate cpu clock");

  property p_wake;
    @(posedge core_clk_in) disable iff (rst_in)
      (!cpu_clk_en_out && grant.valid) |=>
        (cpu_clk_en_out && !state_reg.power_ctl[IDLE_BIT]);
  endproperty
  a_wake: assert property (p_wake)
    else $error("enabled request did not end idle");

  property p_global_gate;
    @(posedge core_clk_in) disable iff (rst_in)
      !state_reg.enable[GLOBAL_EN_BIT] |=> !irq_valid_out;
  endproperty
  a_global_gate: assert property (p_global_gate)
    else $error("request passed with global gate clear");

  property p_top_level;
    @(posedge core_clk_in) disable iff (rst_in)
      state_reg.in_service[LEVEL_TOP] |=> !irq_valid_out;
  endproperty
  a_top_level: assert property (p_top_level)
    else $error("top level service was preempted");

  property p_same_level;
    @(posedge core_clk_in) disable iff (rst_in)
      (busy && grant.level <= cur_lvl) |=> !irq_valid_out;
  endproperty
  a_same_level: assert property (p_same_level)
    else $error("equal or lower level preempted a service");

  property p_higher_first;
    @(posedge core_clk_in) disable iff (rst_in)
      (pending[0] && !busy &&
       !state_reg.prio_high[0] && !state_reg.prio_low[0] &&
       (|(pending[NUM_SOURCES-1:1] &
          (state_reg.prio_high[NUM_SOURCES-1:1] |
           state_reg.prio_low[NUM_SOURCES-1:1]))))
      |=> irq_source_out != 3'h0;
  endproperty
  a_higher_first: assert property (p_higher_first)
    else $error("lower level served before higher");

  property p_poll;
    @(posedge core_clk_in) disable iff (rst_in)
      (pending[0] && !busy && grant.level ==
       {state_reg.prio_high[0], state_reg.prio_low[0]})
      |=> irq_source_out == 3'h0;
  endproperty
  a_poll: assert property (p_poll)
    else $error("polling order not kept within a level");

  property p_merge;
    @(posedge core_clk_in) disable iff (rst_in)
      ((|ca_module_req_in) && state_reg.enable[GLOBAL_EN_BIT] &&
       state_reg.enable[NUM_SOURCES-1] && !busy) |=> irq_valid_out;
  endproperty
  a_merge: assert property (p_merge)
    else $error("array module request not merged");

  // flag write, a cycle with no write, then a read of the same register
  sequence s_flag_write;
    reg_wr_in && reg_addr_in == ADDR_POWER_CTL;
  endsequence

  sequence s_flag_read;
    reg_rd_in && reg_addr_in == ADDR_POWER_CTL;
  endsequence

  property p_flags;
    @(posedge core_clk_in) disable iff (rst_in)
      s_flag_write ##1 !reg_wr_in ##1 s_flag_read
      |=> reg_rdata_out[FLAG_ONE_BIT:FLAG_ZERO_BIT] ==
          $past(reg_wdata_in[FLAG_ONE_BIT:FLAG_ZERO_BIT], 3);
  endproperty
  a_flags: assert property (p_flags)
    else $error("general flags not read back");

  // core takes the offered vector
  sequence s_take;
    ack_in && irq_valid_out;
  endsequence

  property p_accept_level;
    @(posedge core_clk_in) disable iff (rst_in)
      s_take |=> state_reg.in_service[$past(offer_lvl)];
  endproperty
  a_accept_level: assert property (p_accept_level)
    else $error("accepted vector not marked at its level");

  property p_retire;
    @(posedge core_clk_in) disable iff (rst_in)
      (reti_in && busy && !ack_in) |=>
        !state_reg.in_service[$past(cur_lvl)];
  endproperty
  a_retire: assert property (p_retire)
    else $error("return did not end the top service level");

  property p_source_gate;
    @(posedge core_clk_in) disable iff (rst_in)
      !(|(raw_req & state_reg.enable[NUM_SOURCES-1:0])) |=>
        !irq_valid_out;
  endproperty
  a_source_gate: assert property (p_source_gate)
    else $error("request passed with its own enable clear");

  property p_idle_hold;
    @(posedge core_clk_in) disable iff (rst_in)
      (!cpu_clk_en_out && !grant.valid) |=>
        (!cpu_clk_en_out && hold_strobes_out);
  endproperty
  a_idle_hold: assert property (p_idle_hold)
    else $error("idle left or strobes released without a request");

  property p_wake_event;
    @(posedge core_clk_in) disable iff (rst_in)
      (!cpu_clk_en_out && grant.valid) |=>
        state_reg.ev_status[EV_WAKE_BIT];
  endproperty
  a_wake_event: assert property (p_wake_event)
    else $error("wake from idle not recorded");
endmodule : irq_prio_ctrl

// ---- testbench/core_model.sv ----
`timescale 1ns/10ps
// cpu core stand-in: takes one offered vector per arm pulse
module core_model (
  input  wire logic       clk_in,    // machine clock
  input  wire logic       rst_in,    // sync reset
  input  wire logic       arm_in,    // allow one take
  input  wire logic       valid_in,  // vector on offer
  input  wire logic [2:0] source_in, // offered vector
  output logic            ack_out,   // take pulse
  output logic      [2:0] taken_out  // last vector taken
);
  logic armed_reg; // waiting for an offer
  // disarm on take, so a stale offer is never taken twice
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      armed_reg <= 1'b0;
      ack_out   <= 1'b0;
      taken_out <= 3'h0;
    end else begin
      ack_out <= 1'b0;
      if (arm_in) begin
        armed_reg <= 1'b1;
      end else if (armed_reg && valid_in) begin
        armed_reg <= 1'b0;
        ack_out   <= 1'b1;
        taken_out <= source_in;
      end
    end
  end
endmodule : core_model

// ---- testbench/tb.sv ----
`timescale 1ns/10ps
// register-port bench for the priority and idle block
module tb;
  import irq_prio_pkg::*;
  logic       core_clk_in = 1'b0; // machine clock
  logic       rst_in      = 1'b1; // sync reset
  logic [7:0] addr        = 8'h00; // register address
  logic [7:0] wdata       = 8'h00; // write data
  logic       wr          = 1'b0; // write strobe
  logic       rd          = 1'b0; // read strobe
  logic [6:0] req         = 7'h00; // one request per source
  logic [5:0] ca_pick     = 6'h01; // array line used for source 6
  logic       arm         = 1'b0; // core may take one vector
  logic       reti        = 1'b0; // return from service
  logic [7:0] rdata;               // read data
  logic       ack;                 // core take pulse
  logic [2:0] taken;               // vector the core took
  logic       valid;               // vector offered
  logic [2:0] src;                 // offered vector
  logic       cpu_en;              // cpu clock enable
  logic       per_en;              // peripheral clock enable
  logic       hold;                // strobes held
  logic       irq;                 // event interrupt
  logic [1:0] lv;                  // level under test
  int         err_total = 0;       // mismatches
  int         cmp_count = 0;       // comparisons

  irq_prio_ctrl i_dut (
    .core_clk_in      (core_clk_in),
    .rst_in           (rst_in),
    .reg_addr_in      (addr),
    .reg_wdata_in     (wdata),
    .reg_wr_in        (wr),
    .reg_rd_in        (rd),
    .reg_rdata_out    (rdata),
    .ext0_req_in      (req[0]),
    .timer0_req_in    (req[1]),
    .ext1_req_in      (req[2]),
    .timer1_req_in    (req[3]),
    .serial_req_in    (req[4]),
    .timer2_req_in    (req[5]),
    .ca_module_req_in (ca_pick[4:0] & {5{req[6]}}),
    .ca_ovf_req_in    (ca_pick[5] & req[6]),
    .ack_in           (ack),
    .reti_in          (reti),
    .irq_valid_out    (valid),
    .irq_source_out   (src),
    .cpu_clk_en_out   (cpu_en),
    .periph_clk_en_out(per_en),
    .hold_strobes_out (hold),
    .irq_out          (irq)
  );

  core_model i_core (
    .clk_in   (core_clk_in),
    .rst_in   (rst_in),
    .arm_in   (arm),
    .valid_in (valid),
    .source_in(src),
    .ack_out  (ack),
    .taken_out(taken)
  );

  // 100 ns machine clock
  initial begin
    forever #50 core_clk_in = ~core_clk_in;
  end

  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : cmp

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk_in);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge core_clk_in);
    wr    <= 1'b0;
  endtask : wr_reg

  // data stands only in the cycle after the strobe
  task automatic rd_reg(input logic [7:0] a, input logic [7:0] exp);
    @(posedge core_clk_in);
    addr <= a;
    rd   <= 1'b1;
    @(posedge core_clk_in);
    rd   <= 1'b0;
    #1 cmp(rdata, exp);
  endtask : rd_reg

  task automatic setreq(input logic [6:0] r);
    @(posedge core_clk_in);
    req <= r;
  endtask : setreq

  task automatic settle();
    repeat (3) @(posedge core_clk_in);
    #1;
  endtask : settle

  task automatic offer(input logic [2:0] e);
    settle();
    cmp({4'h0, valid, src}, {5'h01, e});
  endtask : offer

  task automatic quiet();
    settle();
    cmp({7'h00, valid}, 8'h00);
  endtask : quiet

  task automatic take(input logic [2:0] e);
    @(posedge core_clk_in);
    arm <= 1'b1;
    @(posedge core_clk_in);
    arm <= 1'b0;
    settle();
    cmp({5'h00, taken}, {5'h00, e});
  endtask : take

  task automatic ret();
    @(posedge core_clk_in);
    reti <= 1'b1;
    @(posedge core_clk_in);
    reti <= 1'b0;
  endtask : ret

  // packs cpu enable, peripheral enable, strobe hold
  task automatic pins(input logic [7:0] e);
    settle();
    cmp({5'h00, cpu_en, per_en, hold}, e);
  endtask : pins

  task automatic irq_is(input logic e);
    settle();
    cmp({7'h00, irq}, {7'h00, e});
  endtask : irq_is

  task automatic close_out();
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : close_out

  // the sequence needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge core_clk_in);
    err_total++;
    $display("BAD t=%0t watchdog expired", $time);
    close_out();
  end

  initial begin
    repeat (16) @(posedge core_clk_in);
    rst_in <= 1'b0;
    rd_reg(ADDR_ENABLE, RESET_BYTE);
    rd_reg(ADDR_PRIO_LOW, RESET_BYTE);
    rd_reg(ADDR_PRIO_HIGH, RESET_BYTE);
    rd_reg(8'h55, 8'h00);
    wr_reg(ADDR_PRIO_LOW, 8'h7F);
    rd_reg(ADDR_PRIO_LOW, 8'h7F);
    wr_reg(ADDR_PRIO_LOW, 8'h00);
    wr_reg(ADDR_ENABLE, 8'h7F);
    setreq(7'h7F);
    quiet();
    // every request raised, one enable bit at a time
    for (int i = 0; i < 7; i++) begin
      wr_reg(ADDR_ENABLE, 8'h80 | (8'h01 << i));
      offer(i[2:0]);
    end
    // each array module and the overflow alone
    setreq(7'h40);
    wr_reg(ADDR_ENABLE, 8'hC0);
    for (int k = 0; k < 6; k++) begin
      @(posedge core_clk_in);
      ca_pick <= 6'h01 << k;
      offer(3'h6);
    end
    // source 2 at level lv, source 4 at level 3 - lv
    wr_reg(ADDR_ENABLE, 8'hFF);
    setreq(7'h15);
    for (int l = 0; l < 4; l++) begin
      lv = l[1:0];
      wr_reg(ADDR_PRIO_LOW, {3'h0, ~lv[0], 1'b0, lv[0], 2'h0});
      wr_reg(ADDR_PRIO_HIGH, {3'h0, ~lv[1], 1'b0, lv[1], 2'h0});
      offer(lv < 2'h2 ? 3'h4 : 3'h2);
    end
    wr_reg(ADDR_PRIO_LOW, 8'h00);
    wr_reg(ADDR_PRIO_HIGH, 8'h00);
    offer(3'h0);
    setreq(7'h7E);
    offer(3'h1);
    // nesting: sources 0 and 1 at level 1, source 3 at level 2
    wr_reg(ADDR_EV_CLEAR, 8'hFF);
    wr_reg(ADDR_PRIO_LOW, 8'h03);
    wr_reg(ADDR_PRIO_HIGH, 8'h08);
    setreq(7'h02);
    offer(3'h1);
    take(3'h1);
    setreq(7'h03);
    quiet();
    setreq(7'h0B);
    offer(3'h3);
    take(3'h3);
    rd_reg(ADDR_EV_STATUS, 8'h06);
    rd_reg(ADDR_IN_SERVICE, 8'h06);
    setreq(7'h00);
    ret();
    ret();
    rd_reg(ADDR_IN_SERVICE, 8'h00);
    // sources 5 and 6 at level 3
    wr_reg(ADDR_PRIO_LOW, 8'h63);
    wr_reg(ADDR_PRIO_HIGH, 8'h68);
    setreq(7'h20);
    offer(3'h5);
    take(3'h5);
    setreq(7'h7F);
    quiet();
    ret();
    offer(3'h5);
    // idle, woken by the one enabled source
    setreq(7'h00);
    wr_reg(ADDR_ENABLE, 8'h81);
    wr_reg(ADDR_EV_CLEAR, 8'hFF);
    wr_reg(ADDR_POWER_CTL, 8'h0D);
    rd_reg(ADDR_POWER_CTL, 8'h0D);
    pins(8'h03);
    setreq(7'h01);
    pins(8'h06);
    rd_reg(ADDR_POWER_CTL, 8'h0C);
    rd_reg(ADDR_EV_STATUS, 8'h01);
    wr_reg(ADDR_EV_ENABLE, 8'h01);
    irq_is(1'b1);
    wr_reg(ADDR_EV_ENABLE, 8'h00);
    irq_is(1'b0);
    wr_reg(ADDR_EV_ENABLE, 8'h01);
    wr_reg(ADDR_EV_CLEAR, 8'h01);
    irq_is(1'b0);
    rd_reg(ADDR_EV_STATUS, 8'h00);
    // idle again, ended by a two-cycle reset
    setreq(7'h00);
    wr_reg(ADDR_POWER_CTL, 8'h01);
    pins(8'h03);
    @(posedge core_clk_in);
    rst_in <= 1'b1;
    repeat (2) @(posedge core_clk_in);
    rst_in <= 1'b0;
    pins(8'h06);
    rd_reg(ADDR_POWER_CTL, 8'h00);
    close_out();
  end
endmodule : tb
